// [park_ctl_pkg.sv]
// constants and types shared by the reset, strap and park control logic
package park_ctl_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_HZ = 50000000;
   localparam int STRAP_DELAY_NS = 1500;
   // strap sample delay in cycles, rounded down, at least one
   localparam int STRAP_DELAY_RAW = (STRAP_DELAY_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
   localparam int STRAP_DELAY_CYC = (STRAP_DELAY_RAW < 1) ? 1 : STRAP_DELAY_RAW;
   localparam int CONFIG_CYC = 16;
   localparam int PARK_CYC = 8;

   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int TP_WIDTH = 8;
   localparam int CNT_WIDTH = 12;
   localparam logic [TP_WIDTH-1:0] STRAP_RESET = 8'h00;
   localparam logic [TP_WIDTH-1:0] STRAP_NORMAL = 8'h00;
   localparam logic [CNT_WIDTH-1:0] CNT_RESET = 12'h000;

   // ---------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_HELD,
      ST_STRAP_WAIT,
      ST_CONFIG,
      ST_RUN,
      ST_PARKING,
      ST_PARKED
   } seq_state_t;

endpackage : park_ctl_pkg

// [sync2.sv]
// two flip-flop level synchroniser with a constant reset value
`timescale 1ns/1ps
module sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic meta;
      logic stable;
   } sync_state_t;

   sync_state_t s_r;
   sync_state_t s_nxt;

   always_comb begin
      s_nxt.meta = async_in;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '{meta: RESET_VAL, stable: RESET_VAL};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sync_out = s_r.stable;
endmodule : sync2

// [reset_park_ctl.sv]
// power-on reset release, test point strap capture and fast park control
// Behaviour
// - start self-configuration on a low-to-high edge of power_on_reset_n
// - keep all outputs inactive while power_on_reset_n is low
// - keep all eight test points high impedance while reset is low
// - sample test points about 1.5 us after release, then drive them
// - in normal operation test points carry only reserved test outputs
// - fast_park_request_n low during configuration or run parks the mirror array quickly
`timescale 1ns/1ps
module reset_park_ctl
   import park_ctl_pkg::*;
#(
   parameter int STRAP_CYC = STRAP_DELAY_CYC,
   parameter int CFG_CYC = CONFIG_CYC,
   parameter int PRK_CYC = PARK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic power_on_reset_n,
   input wire logic fast_park_request_n,
   input wire logic factory_test_enable,
   input wire logic scan_test_reset_n,
   input wire logic [TP_WIDTH-1:0] test_point_in,
   output logic [TP_WIDTH-1:0] test_point_out,
   output logic [TP_WIDTH-1:0] test_point_oe,
   output logic [TP_WIDTH-1:0] test_mode,
   output logic normal_mode,
   output logic config_start,
   output logic config_busy,
   output logic ready,
   output logic mirror_park,
   output logic parked
);

   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   initial begin
      if (STRAP_CYC < 1 || STRAP_CYC >= (1 << CNT_WIDTH)) begin
         $error("STRAP_CYC out of range");
      end
      if (CFG_CYC < 1 || CFG_CYC >= (1 << CNT_WIDTH)) begin
         $error("CFG_CYC out of range");
      end
      if (PRK_CYC < 1 || PRK_CYC >= (1 << CNT_WIDTH)) begin
         $error("PRK_CYC out of range");
      end
   end

   localparam logic [CNT_WIDTH-1:0] STRAP_LAST = CNT_WIDTH'(STRAP_CYC - 1);
   localparam logic [CNT_WIDTH-1:0] CFG_LAST = CNT_WIDTH'(CFG_CYC - 1);
   localparam logic [CNT_WIDTH-1:0] PRK_LAST = CNT_WIDTH'(PRK_CYC - 1);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic por_n_s;
   logic park_n_s;
   logic ftest_s;
   logic scan_rst_n_s;
   logic [TP_WIDTH-1:0] tp_s;

   sync2 #(.RESET_VAL(1'b0)) u_sync_por (
      .clk(clk), .rst(rst), .async_in(power_on_reset_n), .sync_out(por_n_s));
   sync2 #(.RESET_VAL(1'b1)) u_sync_park (
      .clk(clk), .rst(rst), .async_in(fast_park_request_n), .sync_out(park_n_s));
   sync2 #(.RESET_VAL(1'b0)) u_sync_ftest (
      .clk(clk), .rst(rst), .async_in(factory_test_enable), .sync_out(ftest_s));
   sync2 #(.RESET_VAL(1'b0)) u_sync_scan (
      .clk(clk), .rst(rst), .async_in(scan_test_reset_n), .sync_out(scan_rst_n_s));

   genvar gi;
   generate
      for (gi = 0; gi < TP_WIDTH; gi++) begin : g_tp_sync
         sync2 #(.RESET_VAL(1'b0)) u_sync_tp (
            .clk(clk), .rst(rst), .async_in(test_point_in[gi]), .sync_out(tp_s[gi]));
      end
   endgenerate

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      seq_state_t state;
      logic por_prev;
      logic [CNT_WIDTH-1:0] cnt;
      logic [TP_WIDTH-1:0] strap;
      logic [TP_WIDTH-1:0] tp_oe;
      logic [TP_WIDTH-1:0] tp_out;
      logic normal;
      logic cfg_start;
      logic cfg_busy;
      logic rdy;
      logic park;
      logic parked;
   } ctl_state_t;

   ctl_state_t s_r;
   ctl_state_t s_nxt;

   localparam ctl_state_t CTL_RESET = '{
      state: ST_HELD, por_prev: 1'b0, cnt: CNT_RESET, strap: STRAP_RESET,
      tp_oe: '0, tp_out: '0, normal: 1'b0, cfg_start: 1'b0, cfg_busy: 1'b0,
      rdy: 1'b0, park: 1'b0, parked: 1'b0};

   logic por_rise;
   assign por_rise = por_n_s && !s_r.por_prev;

   always_comb begin
      s_nxt = s_r;
      s_nxt.por_prev = por_n_s;
      s_nxt.cfg_start = 1'b0;
      if (!por_n_s) begin
         s_nxt = CTL_RESET;
         s_nxt.por_prev = 1'b0;
      end else begin
         case (s_r.state)
            ST_HELD: begin
               if (por_rise) begin
                  s_nxt.state = ST_STRAP_WAIT;
                  s_nxt.cnt = CNT_RESET;
               end
            end
            ST_STRAP_WAIT: begin
               if (s_r.cnt == STRAP_LAST) begin
                  s_nxt.strap = tp_s;
                  s_nxt.normal = (tp_s == STRAP_NORMAL) && !ftest_s;
                  s_nxt.tp_oe = '1;
                  s_nxt.state = ST_CONFIG;
                  s_nxt.cfg_start = 1'b1;
                  s_nxt.cfg_busy = 1'b1;
                  s_nxt.cnt = CNT_RESET;
               end else begin
                  s_nxt.cnt = s_r.cnt + 1'b1;
               end
            end
            ST_CONFIG: begin
               // configuration waits while scan reset is high
               if (s_r.cnt == CFG_LAST && !scan_rst_n_s) begin
                  s_nxt.cfg_busy = 1'b0;
                  s_nxt.rdy = 1'b1;
                  s_nxt.state = ST_RUN;
               end else if (s_r.cnt != CFG_LAST) begin
                  s_nxt.cnt = s_r.cnt + 1'b1;
               end
            end
            ST_RUN: begin
            end
            ST_PARKING: begin
               if (s_r.cnt == PRK_LAST) begin
                  s_nxt.parked = 1'b1;
                  s_nxt.state = ST_PARKED;
               end else begin
                  s_nxt.cnt = s_r.cnt + 1'b1;
               end
            end
            ST_PARKED: begin
            end
            default: begin
               s_nxt.state = ST_HELD;
            end
         endcase
         // fast park overrides run and config
         if (!park_n_s && (s_r.state == ST_CONFIG || s_r.state == ST_RUN)) begin
            s_nxt.state = ST_PARKING;
            s_nxt.park = 1'b1;
            s_nxt.rdy = 1'b0;
            s_nxt.cfg_busy = 1'b0;
            s_nxt.cnt = CNT_RESET;
         end
         // reserved test output: strap echo in test mode, low otherwise
         s_nxt.tp_out = s_nxt.normal ? '0 : s_nxt.strap;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= CTL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign test_point_out = s_r.tp_out;
   assign test_point_oe = s_r.tp_oe;
   assign test_mode = s_r.strap;
   assign normal_mode = s_r.normal;
   assign config_start = s_r.cfg_start;
   assign config_busy = s_r.cfg_busy;
   assign ready = s_r.rdy;
   assign mirror_park = s_r.park;
   assign parked = s_r.parked;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_released;
      por_n_s && !s_r.por_prev && s_r.state == ST_HELD;
   endsequence

   property p_start_on_rise;
      @(posedge clk) disable iff (rst) s_released |=> s_r.state == ST_STRAP_WAIT;
   endproperty
   a_start_on_rise: assert property (p_start_on_rise) else $error("no start after release");

   property p_inactive_in_reset;
      @(posedge clk) disable iff (rst) !por_n_s |=> !ready && !config_busy && !mirror_park && !parked;
   endproperty
   a_inactive_in_reset: assert property (p_inactive_in_reset) else $error("active in reset");

   property p_one_start;
      @(posedge clk) disable iff (rst) config_start |=> !config_start;
   endproperty
   a_one_start: assert property (p_one_start) else $error("repeated start");

   property p_tristate_in_reset;
      @(posedge clk) disable iff (rst) !por_n_s |=> test_point_oe == '0;
   endproperty
   a_tristate_in_reset: assert property (p_tristate_in_reset) else $error("driving in reset");

   // strap check delay: antecedent already spans two cycles after the edge
   localparam int STRAP_CHK = STRAP_CYC - 1;

   property p_strap_timing;
      @(posedge clk) disable iff (rst || !por_n_s)
         s_released ##1 por_n_s [*2] |-> ##STRAP_CHK test_point_oe == '1;
   endproperty
   a_strap_timing: assert property (p_strap_timing) else $error("strap not sampled on time");

   property p_strap_hold;
      @(posedge clk) disable iff (rst) (por_n_s && s_r.tp_oe == '1 && s_nxt.tp_oe == '1) |=> $stable(test_mode);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

   property p_normal_out_low;
      @(posedge clk) disable iff (rst) normal_mode |-> test_point_out == '0;
   endproperty
   a_normal_out_low: assert property (p_normal_out_low) else $error("test output active");

   property p_fast_park;
      @(posedge clk) disable iff (rst) (por_n_s && !park_n_s && s_r.state == ST_RUN) |=> mirror_park && !ready;
   endproperty
   a_fast_park: assert property (p_fast_park) else $error("park not taken");

endmodule : reset_park_ctl

// [pmic_model.sv]
// behavioural power management partner driving the reset, park, factory test and scan reset pins
`timescale 1ns/1ps
module pmic_model (
   input wire logic clk,
   output logic power_on_reset_n,
   output logic fast_park_request_n,
   output logic factory_test_enable,
   output logic scan_test_reset_n
);
   assign factory_test_enable = 1'b0;

   initial begin
      power_on_reset_n = 1'b0;
      fast_park_request_n = 1'b1;
      scan_test_reset_n = 1'b0;
   end

   // pin drive
   // release only once supplies are stable; park only as a last resort
   task automatic drive(input logic por_n, input logic park_n, input logic scan_n);
      @(posedge clk);
      #1;
      power_on_reset_n = por_n;
      fast_park_request_n = park_n;
      scan_test_reset_n = scan_n;
   endtask : drive
endmodule : pmic_model

// [testbench.sv]
// self-checking bench for reset release, strap capture and fast park
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("Error %s expected %h seen %h", name, exp, got); \
      end \
   end
module testbench
   import park_ctl_pkg::*;
;
   localparam int S_CYC = 4;
   localparam int C_CYC = 2;
   localparam int P_CYC = 2;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic por_n, park_n, fte, scan_n;
   logic [TP_WIDTH-1:0] pull_up = 8'h00;
   logic [TP_WIDTH-1:0] tp_pin, tp_out, tp_oe, tmode;
   logic nmode, cstart, cbusy, rdy, mpark, pkd;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   // pins float to the internal pulldown unless pulled up
   assign tp_pin = (tp_oe & tp_out) | (~tp_oe & pull_up);

   pmic_model i_pmic (.clk(clk), .power_on_reset_n(por_n), .fast_park_request_n(park_n),
      .factory_test_enable(fte), .scan_test_reset_n(scan_n));

   reset_park_ctl #(.STRAP_CYC(S_CYC), .CFG_CYC(C_CYC), .PRK_CYC(P_CYC)) i_dut (
      .clk(clk), .rst(rst), .power_on_reset_n(por_n), .fast_park_request_n(park_n),
      .factory_test_enable(fte), .scan_test_reset_n(scan_n), .test_point_in(tp_pin),
      .test_point_out(tp_out), .test_point_oe(tp_oe), .test_mode(tmode), .normal_mode(nmode),
      .config_start(cstart), .config_busy(cbusy), .ready(rdy), .mirror_park(mpark), .parked(pkd));

   initial begin
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("Error timeout expected below 3000 seen %0d", cycles);
         finish_test();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic wait_hi(ref logic s, input int lim, output int n);
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         step(1);
         n++;
      end
   endtask : wait_hi

   // ---------------------------------------------------------------
   // reset, release and strap sampling
   // ---------------------------------------------------------------
   task automatic start_up(input logic [TP_WIDTH-1:0] pull, input logic pk_n, input logic scan);
      int n;
      pull_up = pull;
      i_pmic.drive(1'b0, 1'b1, scan);
      step(4);
      `CHECK("oe_held", 8'h00, tp_oe)
      `CHECK("outs_held", 6'h00, {nmode, cstart, cbusy, rdy, mpark, pkd})
      `CHECK("strap_clear", 16'h0000, {tmode, tp_out})
      i_pmic.drive(1'b1, pk_n, scan);
      i_pmic.drive(1'b1, 1'b1, scan);
      wait_hi(cstart, S_CYC + 10, n);
      `CHECK("strap_time", S_CYC + 2, n)
      `CHECK("oe_driven", 8'hFF, tp_oe)
      `CHECK("strap", pull, tmode)
      `CHECK("normal", pull == 8'h00, nmode)
      step(1);
      pull_up = 8'h00;
      `CHECK("one_pulse", 2'b01, {cstart, cbusy})
      `CHECK("tp_out", pull, tp_out)
   endtask : start_up

   task automatic test_normal();
      int n;
      start_up(8'h00, 1'b1, 1'b0);
      wait_hi(rdy, C_CYC + 4, n);
      `CHECK("ready", 2'b10, {rdy, cbusy})
      `CHECK("cfg_time", C_CYC - 1, n)
      i_pmic.drive(1'b1, 1'b0, 1'b0);
      wait_hi(mpark, 6, n);
      `CHECK("park_ready", 2'b10, {mpark, rdy})
      `CHECK("park_delay", 3, n)
      wait_hi(pkd, P_CYC + 4, n);
      `CHECK("park_time", P_CYC, n)
      i_pmic.drive(1'b1, 1'b1, 1'b0);
      step(4);
      `CHECK("parked_hold", 1'b1, pkd)
   endtask : test_normal

   task automatic test_strap();
      int n;
      start_up(8'hA5, 1'b0, 1'b0);
      wait_hi(rdy, C_CYC + 4, n);
      step(4);
      `CHECK("early_park", 2'b10, {rdy, mpark})
      `CHECK("strap_held", 8'hA5, tmode)
   endtask : test_strap

   task automatic test_scan_stall();
      int n;
      start_up(8'h00, 1'b1, 1'b1);
      step(C_CYC + 6);
      `CHECK("stalled", 2'b01, {rdy, cbusy})
      i_pmic.drive(1'b1, 1'b1, 1'b0);
      wait_hi(rdy, C_CYC + 8, n);
      `CHECK("resumed", 1'b1, rdy)
      `CHECK("resume_delay", 3, n)
   endtask : test_scan_stall

   task automatic finish_test();
      $display("Comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      step(20);
      rst = 1'b0;
      step(1);
      `CHECK("after_rst", 8'h00, tp_oe)
      test_normal();
      test_strap();
      test_scan_stall();
      finish_test();
   end
endmodule : testbench
